// File: logic/pieb_defines.svh
// Offsets, field positions and reset values of the interrupt enable bank
// Included by the bank's package users; definitions only
`ifndef PIEB_DEFINES_SVH
`define PIEB_DEFINES_SVH

`define PIEB_ADDR_W 8
`define PIEB_DATA_W 8

`define PIEB_ADDR_ENABLE 8'h8C
`define PIEB_ADDR_STATUS 8'h90
`define PIEB_ADDR_CLEAR 8'h91
`define PIEB_ADDR_PENDING 8'h92
`define PIEB_ADDR_DIAG 8'h93

`define PIEB_BIT_TIMER1 0
`define PIEB_BIT_TIMER2 1
`define PIEB_BIT_CAPCOMP1 2
`define PIEB_BIT_SYNCSER 3
`define PIEB_BIT_USART_TX 4
`define PIEB_BIT_USART_RX 5
`define PIEB_BIT_RESERVED6 6
`define PIEB_BIT_PARPORT 7

`define PIEB_ENABLE_RESET 8'h00
`define PIEB_STATUS_RESET 8'h00
`define PIEB_READ_IDLE 8'h00

`define PIEB_MASK_BASE 8'h0F
`define PIEB_MASK_USART 8'h30
`define PIEB_MASK_PARPORT 8'h80
`define PIEB_MASK_BIT6 8'h40
`define PIEB_MASK_BIT7 8'h80

`endif

// File: logic/pieb_pkg.sv
// Types shared by the interrupt enable bank
// Assumes pieb_defines.svh is on the include path
package pieb_pkg;

  typedef logic [7:0] pieb_byte_t;
  typedef logic [7:0] pieb_addr_t;

  typedef enum logic [2:0] {
    PIEB_SEL_NONE = 3'b000,
    PIEB_SEL_ENABLE = 3'b001,
    PIEB_SEL_STATUS = 3'b010,
    PIEB_SEL_CLEAR = 3'b011,
    PIEB_SEL_PENDING = 3'b100,
    PIEB_SEL_DIAG = 3'b101
  } pieb_sel_t;

endpackage

// File: logic/pieb_reset_sync.sv
// Reset release synchroniser for the interrupt enable bank
// Assumes an active-low asynchronous reset from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module pieb_reset_sync (
  input wire logic core_clk,
  input wire logic arst_n,
  output logic rstSync_n
);

  logic stage1_reg;
  logic stage2_reg;

  // Assert at once, release after two edges
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= 1'b1;
      stage2_reg <= stage1_reg;
    end
  end

  assign rstSync_n = stage2_reg;

endmodule // pieb_reset_sync

`default_nettype wire

// File: logic/pieb_event_flag.sv
// One sticky interrupt flag: set by a peripheral event, cleared by software
// Assumes event and clear pulses come from logic on core_clk
`timescale 1ns/1ps
`default_nettype none

module pieb_event_flag #(
  parameter bit IMPLEMENTED = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic setPulse,
  input wire logic clearPulse,
  output logic flag
);

  logic flag_reg;
  logic flag_next;

  // Set wins over a clear in the same cycle
  always_comb begin
    flag_next = flag_reg;
    if (clearPulse) begin
      flag_next = 1'b0;
    end
    if (setPulse) begin
      flag_next = 1'b1;
    end
    if (!IMPLEMENTED) begin
      flag_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

endmodule // pieb_event_flag

`default_nettype wire

// File: logic/pieb_irq_bank.sv
// Peripheral interrupt enable bank with its flags and request output
// Assumes peripheral event pulses on core_clk and a simple register port
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

`include "pieb_defines.svh"

module pieb_irq_bank #(
  parameter bit HAS_USART = 1'b1,
  parameter bit HAS_PARPORT = 1'b1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire pieb_pkg::pieb_addr_t regAddr,
  input wire pieb_pkg::pieb_byte_t regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output pieb_pkg::pieb_byte_t regRdData,
  input wire logic timer1OverflowEvt,
  input wire logic timer2MatchEvt,
  input wire logic capcomp1Evt,
  input wire logic syncSerialEvt,
  input wire logic usartTxEvt,
  input wire logic usartRxEvt,
  input wire logic parallelPortEvt,
  output logic timer1_overflow_irq_en,
  output logic timer2_match_irq_en,
  output logic capcomp1_irq_en,
  output logic sync_serial_irq_en,
  output logic usart_tx_irq_en,
  output logic usart_rx_irq_en,
  output logic parallel_port_irq_en,
  output pieb_pkg::pieb_byte_t gatedIrq,
  output logic periphIrqReq
);

  import pieb_pkg::*;

  // ****************************************************************
  // Variant masks
  // ****************************************************************

  localparam pieb_byte_t IMPL_MASK = `PIEB_MASK_BASE
    | (HAS_USART ? `PIEB_MASK_USART : 8'h00)
    | (HAS_PARPORT ? `PIEB_MASK_PARPORT : 8'h00);

  localparam pieb_byte_t RESV_MASK = `PIEB_MASK_BIT6
    | (HAS_PARPORT ? 8'h00 : `PIEB_MASK_BIT7);

  localparam pieb_byte_t STORE_MASK = IMPL_MASK | RESV_MASK;

  // ****************************************************************
  // Address decode
  // ****************************************************************

  function automatic pieb_sel_t decodeAddr(input pieb_addr_t addr);
    pieb_sel_t sel;
    sel = PIEB_SEL_NONE;
    case (addr)
      `PIEB_ADDR_ENABLE: sel = PIEB_SEL_ENABLE;
      `PIEB_ADDR_STATUS: sel = PIEB_SEL_STATUS;
      `PIEB_ADDR_CLEAR: sel = PIEB_SEL_CLEAR;
      `PIEB_ADDR_PENDING: sel = PIEB_SEL_PENDING;
      `PIEB_ADDR_DIAG: sel = PIEB_SEL_DIAG;
      default: sel = PIEB_SEL_NONE;
    endcase
    return sel;
  endfunction

  // ****************************************************************
  // Reset release
  // ****************************************************************

  logic rst_n;

  pieb_reset_sync resetSync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .rstSync_n(rst_n)
  );

  // ****************************************************************
  // Bus strobes
  // ****************************************************************

  pieb_sel_t wrSel;
  pieb_sel_t rdSel;
  logic enableWr;
  logic clearWr;
  logic diagClearWr;

  assign wrSel = decodeAddr(regAddr);
  assign rdSel = decodeAddr(regAddr);
  assign enableWr = regWrStrobe && (wrSel == PIEB_SEL_ENABLE);
  assign clearWr = regWrStrobe && (wrSel == PIEB_SEL_CLEAR);
  assign diagClearWr = regWrStrobe && (wrSel == PIEB_SEL_DIAG);

  // ****************************************************************
  // Enable register
  // ****************************************************************

  pieb_byte_t enable_reg;
  pieb_byte_t enable_next;

  // Bits outside STORE_MASK never store; reserved bit 6 does store
  always_comb begin
    enable_next = enable_reg;
    if (enableWr) begin
      enable_next = regWrData & STORE_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= `PIEB_ENABLE_RESET;
    end else begin
      enable_reg <= enable_next;
    end
  end

  // ****************************************************************
  // Reserved write monitor
  // ****************************************************************

  logic resvWrite_reg;

  // Sticky note of a one written to a reserved bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resvWrite_reg <= 1'b0;
    end else if (enableWr && ((regWrData & RESV_MASK) != 8'h00)) begin
      resvWrite_reg <= 1'b1;
    end else if (diagClearWr && regWrData[0]) begin
      resvWrite_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Event flags
  // ****************************************************************

  pieb_byte_t eventVec;
  pieb_byte_t flagVec;
  pieb_byte_t clearVec;

  assign eventVec = {parallelPortEvt, 1'b0, usartRxEvt, usartTxEvt,
                     syncSerialEvt, capcomp1Evt, timer2MatchEvt, timer1OverflowEvt};
  assign clearVec = clearWr ? (regWrData & IMPL_MASK) : 8'h00;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : genFlag
      // Flag sets regardless of its enable
      pieb_event_flag #(
        .IMPLEMENTED(IMPL_MASK[gi])
      ) flagBit (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .setPulse(eventVec[gi]),
        .clearPulse(clearVec[gi]),
        .flag(flagVec[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Gating
  // ****************************************************************

  pieb_byte_t gatedVec;
  pieb_byte_t gated_reg;

  assign gatedVec[`PIEB_BIT_TIMER1] =
    flagVec[`PIEB_BIT_TIMER1] & enable_reg[`PIEB_BIT_TIMER1];
  assign gatedVec[`PIEB_BIT_TIMER2] =
    flagVec[`PIEB_BIT_TIMER2] & enable_reg[`PIEB_BIT_TIMER2];
  assign gatedVec[`PIEB_BIT_CAPCOMP1] =
    flagVec[`PIEB_BIT_CAPCOMP1] & enable_reg[`PIEB_BIT_CAPCOMP1];
  assign gatedVec[`PIEB_BIT_SYNCSER] =
    flagVec[`PIEB_BIT_SYNCSER] & enable_reg[`PIEB_BIT_SYNCSER];
  assign gatedVec[`PIEB_BIT_USART_TX] = HAS_USART
    && flagVec[`PIEB_BIT_USART_TX] && enable_reg[`PIEB_BIT_USART_TX];
  assign gatedVec[`PIEB_BIT_USART_RX] = HAS_USART
    && flagVec[`PIEB_BIT_USART_RX] && enable_reg[`PIEB_BIT_USART_RX];
  // Reserved bit gates nothing
  assign gatedVec[`PIEB_BIT_RESERVED6] = 1'b0;
  assign gatedVec[`PIEB_BIT_PARPORT] = HAS_PARPORT
    && flagVec[`PIEB_BIT_PARPORT] && enable_reg[`PIEB_BIT_PARPORT];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gated_reg <= `PIEB_STATUS_RESET;
    end else begin
      gated_reg <= gatedVec;
    end
  end

  // Level request toward the core
  assign periphIrqReq = |gatedVec;
  assign gatedIrq = gated_reg;

  // ****************************************************************
  // Enable outputs to peripherals
  // ****************************************************************

  assign timer1_overflow_irq_en = enable_reg[`PIEB_BIT_TIMER1];
  assign timer2_match_irq_en = enable_reg[`PIEB_BIT_TIMER2];
  assign capcomp1_irq_en = enable_reg[`PIEB_BIT_CAPCOMP1];
  assign sync_serial_irq_en = enable_reg[`PIEB_BIT_SYNCSER];
  assign usart_tx_irq_en = enable_reg[`PIEB_BIT_USART_TX];
  assign usart_rx_irq_en = enable_reg[`PIEB_BIT_USART_RX];
  assign parallel_port_irq_en = HAS_PARPORT && enable_reg[`PIEB_BIT_PARPORT];

  // ****************************************************************
  // Read data
  // ****************************************************************

  pieb_byte_t rdData_reg;
  pieb_byte_t rdData_next;

  always_comb begin
    rdData_next = `PIEB_READ_IDLE;
    if (regRdStrobe) begin
      case (rdSel)
        PIEB_SEL_ENABLE: rdData_next = enable_reg & STORE_MASK;
        PIEB_SEL_STATUS: rdData_next = flagVec & IMPL_MASK;
        PIEB_SEL_PENDING: rdData_next = gatedVec;
        PIEB_SEL_DIAG: rdData_next = {7'h00, resvWrite_reg};
        default: rdData_next = `PIEB_READ_IDLE;
      endcase
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_reg <= `PIEB_READ_IDLE;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;

endmodule // pieb_irq_bank

`default_nettype wire

// File: bench/pieb_periph_model.sv
// Peripheral event source model for the enable bank
// Assumes fire requests arrive on core_clk
`timescale 1ns/1ps
`default_nettype none
module pieb_periph_model (
  input wire logic core_clk,
  input wire logic [7:0] fireMask,
  output logic [6:0] evt
);
  // ****
  // One-cycle event pulses
  // ****
  always_ff @(posedge core_clk) begin
    evt <= {fireMask[7], fireMask[5:0]};
  end
endmodule // pieb_periph_model
`default_nettype wire

// File: bench/pieb_irq_bank_asserts.sv
// Port assertions for the enable bank
// Assumes one core_clk domain; variant parameters follow the bound instance
`timescale 1ns/1ps
`default_nettype none
module pieb_irq_bank_asserts #(
  parameter bit HAS_USART = 1'b1,
  parameter bit HAS_PARPORT = 1'b1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire pieb_pkg::pieb_addr_t regAddr,
  input wire pieb_pkg::pieb_byte_t regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  input wire pieb_pkg::pieb_byte_t regRdData,
  input wire logic timer1OverflowEvt,
  input wire logic timer2MatchEvt,
  input wire logic capcomp1Evt,
  input wire logic syncSerialEvt,
  input wire logic usartTxEvt,
  input wire logic usartRxEvt,
  input wire logic parallelPortEvt,
  input wire logic timer1_overflow_irq_en,
  input wire logic timer2_match_irq_en,
  input wire logic capcomp1_irq_en,
  input wire logic sync_serial_irq_en,
  input wire logic usart_tx_irq_en,
  input wire logic usart_rx_irq_en,
  input wire logic parallel_port_irq_en,
  input wire pieb_pkg::pieb_byte_t gatedIrq,
  input wire logic periphIrqReq
);
  import pieb_pkg::*;
  // ****
  // Checks
  // ****
  logic [7:0] enVec;
  logic [7:0] evtVec;
  assign enVec = {parallel_port_irq_en, 1'b0, usart_rx_irq_en, usart_tx_irq_en,
    sync_serial_irq_en, capcomp1_irq_en, timer2_match_irq_en, timer1_overflow_irq_en};
  assign evtVec = {parallelPortEvt, 1'b0, usartRxEvt, usartTxEvt, syncSerialEvt,
    capcomp1Evt, timer2MatchEvt, timer1OverflowEvt};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  rd_enable_a: assert property (regRdStrobe && regAddr == 8'h8C
    |=> (regRdData & 8'hBF) == $past(enVec)) else $error("enable readback wrong");
  rd_idle_a: assert property (!regRdStrobe |=> regRdData == 8'h00)
    else $error("read data not idle");
  wr_enable_a: assert property (regWrStrobe && regAddr == 8'h8C |=> enVec ==
    ($past(regWrData) & {HAS_PARPORT, 1'b0, HAS_USART, HAS_USART, 4'hF}))
    else $error("enable write wrong");
  gate_mask_a: assert property ((gatedIrq & ~$past(enVec)) == 8'h00)
    else $error("disabled source passed");
  req_track_a: assert property ((|gatedIrq) == $past(periphIrqReq))
    else $error("request and gated copy disagree");
  evt_req_a: assert property ((|(evtVec & enVec)) && !regWrStrobe
    |=> periphIrqReq) else $error("enabled event no request");
  quiet_req_a: assert property (enVec == 8'h00 |-> !periphIrqReq)
    else $error("request with nothing enabled");
  clear_req_a: assert property (regWrStrobe && regAddr == 8'h91
    && regWrData == 8'hFF && evtVec == 8'h00 |=> !periphIrqReq)
    else $error("request after full clear");
  hold_req_a: assert property (periphIrqReq && !regWrStrobe |=> periphIrqReq)
    else $error("request dropped by itself");
  cover property (regWrStrobe && regAddr == 8'h8C);
  cover property ($rose(periphIrqReq));
  cover property (gatedIrq[7]);
endmodule // pieb_irq_bank_asserts
bind pieb_irq_bank pieb_irq_bank_asserts #(.HAS_USART(HAS_USART),
  .HAS_PARPORT(HAS_PARPORT)) u_pieb_irq_bank_asserts (.core_clk(core_clk),
  .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
  .timer1OverflowEvt(timer1OverflowEvt), .timer2MatchEvt(timer2MatchEvt),
  .capcomp1Evt(capcomp1Evt), .syncSerialEvt(syncSerialEvt), .usartTxEvt(usartTxEvt),
  .usartRxEvt(usartRxEvt), .parallelPortEvt(parallelPortEvt),
  .timer1_overflow_irq_en(timer1_overflow_irq_en),
  .timer2_match_irq_en(timer2_match_irq_en), .capcomp1_irq_en(capcomp1_irq_en),
  .sync_serial_irq_en(sync_serial_irq_en), .usart_tx_irq_en(usart_tx_irq_en),
  .usart_rx_irq_en(usart_rx_irq_en), .parallel_port_irq_en(parallel_port_irq_en),
  .gatedIrq(gatedIrq), .periphIrqReq(periphIrqReq));
`default_nettype wire

// File: bench/pieb_irq_bank_test.sv
// Self-checking bench for the enable bank
// Assumes the event model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module pieb_irq_bank_test;
  import pieb_pkg::*;
  // ****
  // Stimulus and checks
  // ****
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  pieb_addr_t regAddr = 8'h00;
  pieb_byte_t regWrData = 8'h00;
  logic regWrStrobe = 1'b0;
  logic regRdStrobe = 1'b0;
  pieb_byte_t regRdData;
  pieb_byte_t gatedIrq;
  pieb_byte_t rd;
  pieb_byte_t rdNu;
  pieb_byte_t regRdDataNu;
  logic periphIrqReq;
  logic [7:0] fireMask = 8'h00;
  logic [6:0] evt;
  logic [6:0] enOut;
  int errCount = 0;
  int numChecks = 0;
  int cycles = 0;
  always #5 core_clk = ~core_clk;
  pieb_periph_model u_pieb_periph_model (.core_clk(core_clk), .fireMask(fireMask),
    .evt(evt));
  pieb_irq_bank u_pieb_irq_bank (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
    .regRdData(regRdData), .timer1OverflowEvt(evt[0]), .timer2MatchEvt(evt[1]),
    .capcomp1Evt(evt[2]), .syncSerialEvt(evt[3]), .usartTxEvt(evt[4]),
    .usartRxEvt(evt[5]), .parallelPortEvt(evt[6]), .timer1_overflow_irq_en(enOut[0]),
    .timer2_match_irq_en(enOut[1]), .capcomp1_irq_en(enOut[2]),
    .sync_serial_irq_en(enOut[3]), .usart_tx_irq_en(enOut[4]),
    .usart_rx_irq_en(enOut[5]), .parallel_port_irq_en(enOut[6]),
    .gatedIrq(gatedIrq), .periphIrqReq(periphIrqReq));
  // Variant with parallel port and no USART, sharing bus and events
  pieb_irq_bank #(.HAS_USART(1'b0), .HAS_PARPORT(1'b1)) u_pieb_irq_bank_nousart (
    .core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdDataNu),
    .timer1OverflowEvt(evt[0]), .timer2MatchEvt(evt[1]), .capcomp1Evt(evt[2]),
    .syncSerialEvt(evt[3]), .usartTxEvt(evt[4]), .usartRxEvt(evt[5]),
    .parallelPortEvt(evt[6]), .timer1_overflow_irq_en(), .timer2_match_irq_en(),
    .capcomp1_irq_en(), .sync_serial_irq_en(), .usart_tx_irq_en(), .usart_rx_irq_en(),
    .parallel_port_irq_en(), .gatedIrq(), .periphIrqReq());
  task automatic check(input pieb_byte_t seen, input pieb_byte_t exp);
    numChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrReg(input pieb_addr_t a, input pieb_byte_t d);
    @(posedge core_clk);
    regWrStrobe <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrStrobe <= 1'b0;
  endtask
  task automatic rdReg(input pieb_addr_t a);
    @(posedge core_clk);
    regRdStrobe <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdStrobe <= 1'b0;
    #1 rd = regRdData;
    rdNu = regRdDataNu;
  endtask
  task automatic fire(input pieb_byte_t m);
    @(posedge core_clk);
    fireMask <= m;
    @(posedge core_clk);
    fireMask <= 8'h00;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic testReset();
    rdReg(8'h8C);
    check(rd, 8'h00);
    rdReg(8'h90);
    check(rd, 8'h00);
    check({periphIrqReq, enOut}, 8'h00);
    $display("reset test done");
  endtask
  task automatic testRegs();
    wrReg(8'h8C, 8'hBF);
    rdReg(8'h8C);
    check(rd, 8'hBF);
    check(rdNu, 8'h8F);
    check({1'b0, enOut}, 8'h7F);
    wrReg(8'h8C, 8'h95);
    rdReg(8'h8C);
    check(rd, 8'h95);
    check(rdNu, 8'h85);
    check({1'b0, enOut}, 8'h55);
    wrReg(8'h55, 8'hFF);
    rdReg(8'h55);
    check(rd, 8'h00);
    wrReg(8'h90, 8'hFF);
    rdReg(8'h90);
    check(rd, 8'h00);
    rdReg(8'h93);
    check(rd, 8'h00);
    wrReg(8'h8C, 8'h00);
    $display("register test done");
  endtask
  task automatic testGate();
    int bits[7] = '{0, 1, 2, 3, 4, 5, 7};
    pieb_byte_t m;
    for (int k = 0; k < 7; k++) begin
      m = 8'h01 << bits[k];
      wrReg(8'h91, 8'hFF);
      wrReg(8'h8C, 8'hBF & ~m);
      fire(m);
      check({7'h00, periphIrqReq}, 8'h00);
      rdReg(8'h90);
      check(rd, m);
      check(rdNu, m & 8'hCF);
      wrReg(8'h8C, m);
      rdReg(8'h92);
      check(rd, m);
      check({7'h00, periphIrqReq}, 8'h01);
      check(gatedIrq, m);
      wrReg(8'h91, m);
      rdReg(8'h90);
      check(rd, 8'h00);
      check({7'h00, periphIrqReq}, 8'h00);
    end
    $display("gate test done");
  endtask
  task automatic testMidReset();
    wrReg(8'h8C, 8'h95);
    fire(8'h01);
    check({7'h00, periphIrqReq}, 8'h01);
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdReg(8'h8C);
    check(rd, 8'h00);
    rdReg(8'h90);
    check(rd, 8'h00);
    check({periphIrqReq, enOut}, 8'h00);
    check(gatedIrq, 8'h00);
    $display("mid-run reset test done");
  endtask
  task automatic testDone();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errCount++;
      testDone();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    testReset();
    testRegs();
    testGate();
    testMidReset();
    testDone();
  end
endmodule // pieb_irq_bank_test
`default_nettype wire
